/* hw/mtp_config_store_consts.svh */
// Behaviour
// (R1) store holds 16-bit words, 57 of them for customer use, all rewritable
// (R2) customer write commands use codes 40h to 79h
// (R3) factory trim sector is never altered by customer writes
// (R4) one word programs within 16 ms of its command
// (R5) host reads each programmed word back and compares it; the testbench compares only in the config test and for the checksum word
// (R6) customer identifier is word 01 over word 00, both default zero
// (R7) serial slave address is word 02 bits 6:0, any value, default zero
// (R8) slave addresses 04h to 07h are reserved for high-speed entry
// (R9) interrupt setup bits 8:7; 00 gives plain end of conversion
// (R10) setup 01: output rises above limit one, falls below it
// (R11) setup 10: output rises below limit one, falls above it
// (R12) setup 11: window comparison between limit one and limit two
// (R13) bit 9 sets select polarity; device answers only while selected
// (R14) bits 11:10 set serial clock idle level and capture edge
// (R15) bits 14:12 set cyclic sleep period 125 ms to 4000 ms
// (R16) bit 15 picks parabolic or s-shaped second-order correction
// (R17) integrity flag computed only at power-up, status bit 2; the code computes it once after every reset
// (R18) customer writes outside the customer sector are ignored silently; the code ignores them but sets the write-refused interrupt event
`ifndef MTP_CONFIG_STORE_CONSTS_SVH
`define MTP_CONFIG_STORE_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_COMMAND 8'h00
`define REG_WORD_DATA 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STATUS 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_LIMIT_ONE 8'h14
`define REG_LIMIT_TWO 8'h18
`define REG_CUSTOMER_ID 8'h1C

// ----------------------------------------------------------------
// store layout and command codes
// ----------------------------------------------------------------
`define CUST_WORDS 57
`define WORD_CUST_ID_LOW 6'h00
`define WORD_CUST_ID_HIGH 6'h01
`define WORD_IF_CONFIG 6'h02
`define WORD_CHECKSUM 6'h38
`define CMD_WRITE_FIRST 8'h40
`define CMD_WRITE_LAST 8'h79
`define CMD_READ_LAST 8'h38
`define WORD_RESET 16'h0000
`define HS_ADDR_FIRST 7'h04
`define HS_ADDR_LAST 7'h07

// ----------------------------------------------------------------
// status bits and interrupt events
// ----------------------------------------------------------------
`define STAT_BUSY 5
`define STAT_MEM_ERROR 2
`define IRQ_PROG_DONE 0
`define IRQ_WRITE_REFUSED 1
`define IRQ_OUTPUT_ROSE 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ 100000
`define PROG_TIME_MS 16
`define PROG_CYCLES (`PROG_TIME_MS * `CLK_FREQ_KHZ)
`define SLEEP_BASE_MS 13'h007D

`endif

/* hw/mtp_config_store_pkg.sv */
package mtp_config_store_pkg;

    // ----------------------------------------------------------------
    // bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // interface configuration word
    typedef struct packed {
        logic second_order_shape;
        logic [2:0] cyclic_sleep_period;
        logic [1:0] serial_clock_mode;
        logic ss_polarity;
        logic [1:0] int_setup;
        logic [6:0] slave_addr;
    } if_config_t;

    // decoded serial clock mode
    typedef struct packed {
        logic idle_high;
        logic capture_rising;
        logic drive_rising;
    } clock_mode_t;

    typedef enum logic [1:0] {
        INT_EOC,
        INT_ABOVE,
        INT_BELOW,
        INT_WINDOW
    } int_setup_t;

    // whole register state of the store, apart from the word array mem
    typedef struct packed {
        logic ack;
        logic [31:0] rd_dat;
        logic busy;
        logic [20:0] prog_cnt;
        logic [5:0] prog_idx;
        logic [15:0] word_data;
        logic check_done;
        logic mem_error;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [23:0] limit_one;
        logic [23:0] limit_two;
        logic conv_out;
        logic ss_meta;
        logic ss_sync;
    } state_t;

endpackage : mtp_config_store_pkg

/* hw/mtp_config_store.sv */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mtp_config_store_consts.svh"

module mtp_config_store #(
    parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // register bus
    input wire mtp_config_store_pkg::wb_req_t i_wb,
    output mtp_config_store_pkg::wb_rsp_t o_wb,
    // measurement feed
    input wire logic [23:0] i_conditioned_result,
    input wire logic i_result_valid,
    input wire logic i_conv_start,
    // slave select pin
    input wire logic i_ss_pin,
    // decoded configuration
    output logic [31:0] o_customer_id,
    output logic [6:0] o_slave_addr,
    output logic o_addr_reserved,
    output logic o_ss_active_high,
    output logic o_selected,
    output mtp_config_store_pkg::clock_mode_t o_serial_clock_mode,
    output logic [12:0] o_cyclic_sleep_ms,
    output logic o_cyclic_sleep_valid,
    output logic o_second_order_scurve,
    // conversion pin, interrupt, integrity
    output logic o_eoc_int,
    output logic o_irq,
    output logic o_mem_error
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] mem [`CUST_WORDS] = '{default: `WORD_RESET}; // power-up contents, untouched by reset
    mtp_config_store_pkg::state_t s_q;
    mtp_config_store_pkg::state_t s_d;
    mtp_config_store_pkg::if_config_t cfg;
    logic [15:0] sum;
    logic req;
    logic wr;
    logic [7:0] cmd;
    logic prog_end;
    logic [2:0] ev;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // configuration word and checksum over every word before the checksum
    always_comb begin
        cfg = mtp_config_store_pkg::if_config_t'(mem[`WORD_IF_CONFIG]);
        sum = 16'h0000;
        for (int i = 0; i < int'(`WORD_CHECKSUM); i++) begin
            sum = sum ^ mem[i];
        end
    end

    assign req = i_wb.cyc & i_wb.stb & ~s_q.ack;
    assign wr = req & i_wb.we;
    assign cmd = i_wb.dat[7:0];
    assign prog_end = s_q.busy && (s_q.prog_cnt == 21'(PROG_CYCLES - 1));

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        ev = 3'h0;
        s_d.ack = req;
        // select pin passes two flops before use
        s_d.ss_meta = i_ss_pin;
        s_d.ss_sync = s_q.ss_meta;
        // integrity flag taken once after reset only
        if (!s_q.check_done) begin
            s_d.check_done = 1'b1;
            s_d.mem_error = (sum != mem[`WORD_CHECKSUM]); // see (R17)
        end
        // programming timer
        if (s_q.busy) begin
            s_d.prog_cnt = s_q.prog_cnt + 21'h000001;
            if (prog_end) begin
                s_d.busy = 1'b0; // see (R4)
                s_d.prog_cnt = 21'h000000;
                ev[`IRQ_PROG_DONE] = 1'b1;
            end
        end
        // register writes
        if (wr) begin
            if (i_wb.adr == `REG_COMMAND) begin
                if (i_wb.sel[0] && !s_q.busy && s_q.check_done) begin
                    if (cmd >= `CMD_WRITE_FIRST && cmd <= `CMD_WRITE_LAST) begin // see (R2)
                        if ((cmd - `CMD_WRITE_FIRST) < 8'(`CUST_WORDS)) begin
                            s_d.busy = 1'b1;
                            s_d.prog_idx = 6'(cmd - `CMD_WRITE_FIRST);
                        end else begin
                            ev[`IRQ_WRITE_REFUSED] = 1'b1; // see (R18)
                        end
                    end else if (cmd <= `CMD_READ_LAST) begin
                        s_d.word_data = mem[6'(cmd)];
                    end else begin
                        ev[`IRQ_WRITE_REFUSED] = 1'b1; // see (R3)
                    end
                end
            end else if (i_wb.adr == `REG_WORD_DATA) begin
                if (!s_q.busy) begin
                    s_d.word_data = 16'(merge({16'h0000, s_q.word_data}, i_wb.dat, i_wb.sel));
                end
            end else if (i_wb.adr == `REG_IRQ_STATUS) begin
                s_d.irq_stat = s_q.irq_stat & ~(i_wb.dat[2:0] & {3{i_wb.sel[0]}});
            end else if (i_wb.adr == `REG_IRQ_MASK) begin
                if (i_wb.sel[0]) begin
                    s_d.irq_mask = i_wb.dat[2:0];
                end
            end else if (i_wb.adr == `REG_LIMIT_ONE) begin
                s_d.limit_one = 24'(merge({8'h00, s_q.limit_one}, i_wb.dat, i_wb.sel));
            end else if (i_wb.adr == `REG_LIMIT_TWO) begin
                s_d.limit_two = 24'(merge({8'h00, s_q.limit_two}, i_wb.dat, i_wb.sel));
            end
        end
        // register reads
        s_d.rd_dat = 32'h00000000;
        if (req && !i_wb.we) begin
            if (i_wb.adr == `REG_WORD_DATA) begin
                s_d.rd_dat = {16'h0000, s_q.word_data};
            end else if (i_wb.adr == `REG_STATUS) begin
                s_d.rd_dat[`STAT_BUSY] = s_q.busy;
                s_d.rd_dat[`STAT_MEM_ERROR] = s_q.mem_error;
            end else if (i_wb.adr == `REG_IRQ_STATUS) begin
                s_d.rd_dat = {29'h00000000, s_q.irq_stat};
            end else if (i_wb.adr == `REG_IRQ_MASK) begin
                s_d.rd_dat = {29'h00000000, s_q.irq_mask};
            end else if (i_wb.adr == `REG_LIMIT_ONE) begin
                s_d.rd_dat = {8'h00, s_q.limit_one};
            end else if (i_wb.adr == `REG_LIMIT_TWO) begin
                s_d.rd_dat = {8'h00, s_q.limit_two};
            end else if (i_wb.adr == `REG_CUSTOMER_ID) begin
                s_d.rd_dat = {mem[`WORD_CUST_ID_HIGH], mem[`WORD_CUST_ID_LOW]}; // see (R6)
            end
        end
        // conversion pin behaviour
        case (mtp_config_store_pkg::int_setup_t'(cfg.int_setup)) // see (R9)
            mtp_config_store_pkg::INT_EOC: begin
                if (i_result_valid) begin
                    s_d.conv_out = 1'b1;
                end else if (i_conv_start) begin
                    s_d.conv_out = 1'b0;
                end
            end
            mtp_config_store_pkg::INT_ABOVE: begin
                if (i_result_valid) begin
                    if (i_conditioned_result > s_q.limit_one) begin
                        s_d.conv_out = 1'b1; // see (R10)
                    end else if (i_conditioned_result < s_q.limit_one) begin
                        s_d.conv_out = 1'b0; // see (R10)
                    end
                end
            end
            mtp_config_store_pkg::INT_BELOW: begin
                if (i_result_valid) begin
                    if (i_conditioned_result < s_q.limit_one) begin
                        s_d.conv_out = 1'b1; // see (R11)
                    end else if (i_conditioned_result > s_q.limit_one) begin
                        s_d.conv_out = 1'b0; // see (R11)
                    end
                end
            end
            default: begin
                if (i_result_valid) begin
                    if (s_q.limit_one > s_q.limit_two) begin
                        s_d.conv_out = !(i_conditioned_result >= s_q.limit_two &&
                                         i_conditioned_result < s_q.limit_one); // see (R12)
                    end else begin
                        s_d.conv_out = (i_conditioned_result >= s_q.limit_one &&
                                        i_conditioned_result < s_q.limit_two); // see (R12)
                    end
                end
            end
        endcase
        if (s_d.conv_out && !s_q.conv_out) begin
            ev[`IRQ_OUTPUT_ROSE] = 1'b1;
        end
        // new events win over a clear in the same cycle
        s_d.irq_stat = s_d.irq_stat | ev;
        if (!i_rst_b) begin
            s_d = '0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        s_q <= s_d;
    end

    // word programming lands at the end of the programming time
    always_ff @(posedge i_clk_sys) begin
        if (i_rst_b && prog_end) begin
            mem[s_q.prog_idx] <= s_q.word_data; // see (R1) (R3)
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // bus answer
    assign o_wb.ack = s_q.ack;
    assign o_wb.dat = s_q.rd_dat;

    // decoded configuration
    always_comb begin
        o_customer_id = {mem[`WORD_CUST_ID_HIGH], mem[`WORD_CUST_ID_LOW]}; // see (R6)
        o_slave_addr = cfg.slave_addr; // see (R7)
        o_addr_reserved = (cfg.slave_addr >= `HS_ADDR_FIRST) && (cfg.slave_addr <= `HS_ADDR_LAST); // see (R8)
        o_ss_active_high = cfg.ss_polarity;
        o_selected = (s_q.ss_sync == cfg.ss_polarity); // see (R13)
        o_serial_clock_mode.idle_high = cfg.serial_clock_mode[1]; // see (R14)
        o_serial_clock_mode.capture_rising = (cfg.serial_clock_mode == 2'h0) || (cfg.serial_clock_mode == 2'h3);
        o_serial_clock_mode.drive_rising = (cfg.serial_clock_mode != 2'h0);
        o_cyclic_sleep_valid = (cfg.cyclic_sleep_period != 3'h0) && (cfg.cyclic_sleep_period != 3'h7);
        o_cyclic_sleep_ms = 13'h0000;
        if (o_cyclic_sleep_valid) begin
            o_cyclic_sleep_ms = `SLEEP_BASE_MS << (cfg.cyclic_sleep_period - 3'h1); // see (R15)
        end
        o_second_order_scurve = cfg.second_order_shape; // see (R16)
    end

    // pin, interrupt and integrity flag
    assign o_eoc_int = s_q.conv_out;
    assign o_irq = |(s_q.irq_stat & s_q.irq_mask);
    assign o_mem_error = s_q.mem_error;

endmodule : mtp_config_store

/* dv/mtp_config_store_properties.sv */
`timescale 1ns/1ps

module mtp_config_store_properties #(
    parameter int unsigned PROG_CYCLES = 20
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // bus and pins
    input wire mtp_config_store_pkg::wb_req_t i_wb,
    input wire mtp_config_store_pkg::wb_rsp_t o_wb,
    input wire logic i_ss_pin,
    // decoded outputs
    input wire logic [6:0] o_slave_addr,
    input wire logic o_addr_reserved,
    input wire logic o_ss_active_high,
    input wire logic o_selected,
    input wire mtp_config_store_pkg::clock_mode_t o_serial_clock_mode,
    input wire logic [12:0] o_cyclic_sleep_ms,
    input wire logic o_cyclic_sleep_valid,
    input wire logic o_mem_error
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    logic [1:0] run_q;
    // counts edges since reset so the power-up check is past
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) run_q <= 2'h0;
        else if (run_q != 2'h3) run_q <= run_q + 2'h1;
    end
    ack_pulse_a: assert property (o_wb.ack |=> !o_wb.ack) else $error("ack longer than one cycle");
    ack_follow_a: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack) else $error("no ack");
    dat_idle_a: assert property (!o_wb.ack |-> o_wb.dat == 32'h0) else $error("read data without ack");
    addr_reserved_a: assert property (o_addr_reserved == (o_slave_addr inside {[7'h04:7'h07]}))
        else $error("reserved address flag wrong");
    sleep_decode_a: assert property (o_cyclic_sleep_valid == (o_cyclic_sleep_ms inside
        {13'h007D, 13'h00FA, 13'h01F4, 13'h03E8, 13'h07D0, 13'h0FA0})) else $error("sleep period wrong");
    clock_mode_a: assert property (o_serial_clock_mode.idle_high ? o_serial_clock_mode.drive_rising
        : o_serial_clock_mode.capture_rising != o_serial_clock_mode.drive_rising) else $error("clock mode");
    select_on_a: assert property ((i_ss_pin == o_ss_active_high) [*4] |-> o_selected)
        else $error("select not seen");
    select_off_a: assert property ((i_ss_pin != o_ss_active_high) [*4] |-> !o_selected)
        else $error("select seen while idle");
    integrity_hold_a: assert property (run_q == 2'h3 |-> $stable(o_mem_error))
        else $error("integrity flag moved after power-up");
    cover property (o_wb.ack && i_wb.we);
    cover property (o_addr_reserved);
    cover property (run_q == 2'h2 && o_mem_error);
endmodule : mtp_config_store_properties

bind mtp_config_store mtp_config_store_properties #(.PROG_CYCLES(PROG_CYCLES)) i_mtp_config_store_properties (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wb(i_wb), .o_wb(o_wb), .i_ss_pin(i_ss_pin),
    .o_slave_addr(o_slave_addr), .o_addr_reserved(o_addr_reserved), .o_ss_active_high(o_ss_active_high),
    .o_selected(o_selected), .o_serial_clock_mode(o_serial_clock_mode), .o_cyclic_sleep_ms(o_cyclic_sleep_ms),
    .o_cyclic_sleep_valid(o_cyclic_sleep_valid), .o_mem_error(o_mem_error));

/* dv/mtp_host.sv */
`timescale 1ns/1ps
`include "mtp_config_store_consts.svh"

module mtp_host (
    // clock
    input wire logic i_clk_sys,
    // register bus
    output mtp_config_store_pkg::wb_req_t o_wb,
    input wire mtp_config_store_pkg::wb_rsp_t i_wb
);
    initial o_wb = '0;
    // one classic cycle; released lines carry inverted leftovers
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk_sys);
        o_wb <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: 4'hF, dat: d};
        do @(posedge i_clk_sys); while (i_wb.ack !== 1'h1);
        q = i_wb.dat;
        o_wb <= '{cyc: 1'h0, stb: 1'h0, we: ~we, adr: ~a, sel: 4'h0, dat: ~d};
    endtask : xfer
    // program one word, poll busy, then read it back
    task automatic prog(input logic [5:0] w, input logic [15:0] v, output logic [15:0] back, output int n);
        logic [31:0] q;
        xfer(1'h1, `REG_WORD_DATA, {16'h0000, v}, q);
        xfer(1'h1, `REG_COMMAND, {24'h000000, 2'h1, w}, q);
        n = 0;
        do begin
            xfer(1'h0, `REG_STATUS, 32'h0, q);
            n += 3;
        end while (q[`STAT_BUSY] !== 1'h0 && n < 600);
        xfer(1'h1, `REG_COMMAND, {26'h0000000, w}, q);
        xfer(1'h0, `REG_WORD_DATA, 32'h0, q);
        back = q[15:0];
    endtask : prog
endmodule : mtp_host

/* dv/tb_mtp_config_store.sv */
`timescale 1ns/1ps
`include "mtp_config_store_consts.svh"

module tb_mtp_config_store;
    localparam int unsigned PROG = 20;
    logic i_clk_sys, i_rst_b, valid, start, ss, sleep_ok, scurve, eoc, irq, mem_err, a_res, ss_hi, sel;
    logic [23:0] res;
    logic [31:0] cid;
    logic [31:0] r;
    logic [15:0] back;
    logic [6:0] addr;
    logic [12:0] sleep;
    mtp_config_store_pkg::wb_req_t wq;
    mtp_config_store_pkg::wb_rsp_t wr_s;
    mtp_config_store_pkg::clock_mode_t cm;
    int fails, n_compared, n;
    logic [15:0] cfg [4] = '{16'h1405, 16'h6A12, 16'hFC7F, 16'h3007};
    logic [26:0] conv [7] = '{{2'h1, 24'h0005DC, 1'h1}, {2'h1, 24'h000320, 1'h0}, {2'h2, 24'h000320, 1'h1},
        {2'h2, 24'h0005DC, 1'h0}, {2'h3, 24'h0002BC, 1'h0}, {2'h3, 24'h0004B0, 1'h1}, {2'h3, 24'h000190, 1'h1}};
    mtp_config_store #(.PROG_CYCLES(PROG)) i_mtp_config_store (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_wb(wq), .o_wb(wr_s), .i_conditioned_result(res), .i_result_valid(valid), .i_conv_start(start),
        .i_ss_pin(ss), .o_customer_id(cid), .o_slave_addr(addr), .o_addr_reserved(a_res), .o_ss_active_high(ss_hi),
        .o_selected(sel), .o_serial_clock_mode(cm), .o_cyclic_sleep_ms(sleep), .o_cyclic_sleep_valid(sleep_ok),
        .o_second_order_scurve(scurve), .o_eoc_int(eoc), .o_irq(irq), .o_mem_error(mem_err));
    mtp_host i_mtp_host (.i_clk_sys(i_clk_sys), .o_wb(wq), .i_wb(wr_s));
    initial begin
        i_clk_sys = 1'h0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // compare and report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic do_reset();
        i_rst_b <= 1'h0;
        repeat (12) @(posedge i_clk_sys);
        i_rst_b <= 1'h1;
        repeat (2) @(posedge i_clk_sys);
    endtask : do_reset
    task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
        i_mtp_host.xfer(we, a, d, r);
    endtask : acc
    // one measurement, then let the pin settle
    task automatic feed(input logic [23:0] m);
        @(posedge i_clk_sys);
        res <= m;
        valid <= 1'h1;
        @(posedge i_clk_sys);
        valid <= 1'h0;
        @(posedge i_clk_sys);
    endtask : feed
    initial begin
        {valid, start, ss, res, fails, n_compared} = '0;
        do_reset();
        acc(1'h0, `REG_CUSTOMER_ID, 32'h0);
        chk("customer id", r, 32'h0);
        chk("slave addr", addr, 32'h0);
        acc(1'h0, `REG_STATUS, 32'h0);
        chk("status", r, 32'h0);
        $display("test defaults done");
        foreach (cfg[i]) begin
            i_mtp_host.prog(`WORD_IF_CONFIG, cfg[i], back, n);
            chk("readback", back, cfg[i]);
            chk("program time", n <= PROG + 6, 1);
            chk("slave addr", addr, cfg[i][6:0]);
            chk("reserved", a_res, cfg[i][6:0] inside {[7'h04:7'h07]});
            chk("polarity", ss_hi, cfg[i][9]);
            chk("clock mode", cm, {cfg[i][11], cfg[i][11] == cfg[i][10], cfg[i][11:10] != 2'h0});
            chk("sleep", sleep, cfg[i][14:12] inside {[1:6]} ? 13'h007D << (cfg[i][14:12] - 1) : 0);
            chk("shape", scurve, cfg[i][15]);
            ss <= cfg[i][9];
            repeat (5) @(posedge i_clk_sys);
            chk("selected", sel, 1);
            ss <= ~cfg[i][9];
            repeat (5) @(posedge i_clk_sys);
            chk("deselected", sel, 0);
        end
        $display("test config done");
        chk("integrity before reset", mem_err, 0);
        do_reset();
        chk("integrity after reset", mem_err, 1);
        i_mtp_host.prog(`WORD_CHECKSUM, 16'h3007, back, n);
        chk("last word", back, 16'h3007);
        do_reset();
        chk("integrity repaired", mem_err, 0);
        $display("test integrity done");
        i_mtp_host.prog(`WORD_CUST_ID_LOW, 16'hA55A, back, n);
        i_mtp_host.prog(`WORD_CUST_ID_HIGH, 16'h3C96, back, n);
        chk("id pins", cid, 32'h3C96A55A);
        $display("test id done");
        // only the programming-done event has happened since the last reset
        acc(1'h0, `REG_IRQ_STATUS, 32'h0);
        chk("done event", r, 32'h1);
        chk("irq idle", irq, 0);
        acc(1'h1, `REG_IRQ_STATUS, 32'h7);
        acc(1'h1, `REG_IRQ_MASK, 32'h2);
        acc(1'h1, `REG_COMMAND, 32'h79);
        acc(1'h0, `REG_IRQ_STATUS, 32'h0);
        chk("refused", r, 32'h2);
        chk("irq", irq, 1);
        acc(1'h0, `REG_CUSTOMER_ID, 32'h0);
        chk("id kept", r, 32'h3C96A55A);
        acc(1'h1, `REG_IRQ_MASK, 32'h0);
        chk("irq masked", irq, 0);
        acc(1'h1, `REG_IRQ_STATUS, 32'h2);
        acc(1'h0, `REG_IRQ_STATUS, 32'h0);
        chk("cleared", r, 32'h0);
        acc(1'h0, 8'h20, 32'h0);
        chk("unmapped", r, 32'h0);
        $display("test refusal done");
        acc(1'h1, `REG_LIMIT_ONE, 32'h3E8);
        acc(1'h1, `REG_LIMIT_TWO, 32'h1F4);
        i_mtp_host.prog(`WORD_IF_CONFIG, 16'h0000, back, n);
        feed(24'h000005);
        chk("eoc set", eoc, 1);
        start <= 1'h1;
        @(posedge i_clk_sys);
        start <= 1'h0;
        repeat (2) @(posedge i_clk_sys);
        chk("eoc clear", eoc, 0);
        foreach (conv[i]) begin
            if (i == 0 || conv[i][26:25] != conv[i - 1][26:25])
                i_mtp_host.prog(`WORD_IF_CONFIG, {7'h00, conv[i][26:25], 7'h00}, back, n);
            feed(conv[i][24:1]);
            chk("threshold pin", eoc, conv[i][0]);
        end
        // window with limit one below limit two: high only inside the band
        acc(1'h1, `REG_IRQ_STATUS, 32'h7);
        acc(1'h1, `REG_LIMIT_ONE, 32'h1F4);
        acc(1'h1, `REG_LIMIT_TWO, 32'h3E8);
        feed(24'h0003E8);
        chk("window top", eoc, 0);
        feed(24'h0002BC);
        chk("window inside", eoc, 1);
        acc(1'h0, `REG_IRQ_STATUS, 32'h0);
        chk("pin rose event", r, 32'h4);
        $display("test threshold done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fails++;
        wrap_up();
    end
endmodule : tb_mtp_config_store
